//--- src/anps_regs.v
// Purpose: auto-negotiation partner ability and expansion registers
// Assumes: negotiation engine drives same-clock pulses and levels
// Notes: unmapped addresses read zero with SLVERR; only the interrupt mask stores writes
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "anps_defines.vh"

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - partner word loads register 5 on page arrival; software cannot write.
// - bit 15 shows partner further page; resets to zero.
// - acknowledge bit comes only from received bursts; writes ignored.
// - bit 13 shows partner remote fault; resets to zero.
// - reserved bits read zero; writes to them discarded.
// - bit 10 shows partner pause capability.
// - bits 9..5 show partner technologies, one each.
// - bits 4..0 hold partner selector; reset zero.
// - parallel detection fault latches high in register 6.
// - bit 3 shows partner next page capability.
// - local next page capable bit is always zero.
// - page received bit latches high on each new page.
// - reading register 6 clears page received.
// - bit 0 shows partner supports auto-negotiation.
module anps_regs
(
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire page_strobe,
  input wire [15:0] page_word,
  input wire parallel_detect_fault,
  input wire partner_page_capable,
  input wire partner_negotiation_capable,
  output wire irq
);

  reg [15:0] ability_r;
  reg fault_r;
  reg page_rx_r;
  reg [1:0] irq_stat_r;
  reg [1:0] irq_mask_r;
  reg aw_got_r;
  reg w_got_r;
  reg [4:0] aw_idx_r;
  reg [1:0] mask_data_r;
  reg mask_strb_r;
  wire [4:0] ar_idx;
  wire rd_take;
  wire rd_expan;
  wire rd_stat;
  wire wr_fire;
  reg [31:0] rdata_nxt;
  reg rresp_err_nxt;
  wire [15:0] expan_word;

  ////////////////////////////////////////////////////////////////////////////////
  // Read channel: one outstanding read, address taken when no data pending
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_take = s_axi_arvalid & s_axi_arready;
  assign ar_idx = s_axi_araddr[6:2];
  assign rd_expan = rd_take & (ar_idx == `ANPS_IDX_EXPAN);
  assign rd_stat = rd_take & (ar_idx == `ANPS_IDX_IRQ_STAT);

  assign expan_word = {11'h000,
    fault_r,
    partner_page_capable,
    1'b0,
    page_rx_r,
    partner_negotiation_capable};

  always @*
  begin
    rdata_nxt = 32'h00000000;
    rresp_err_nxt = 1'b0;
    case (ar_idx)
      `ANPS_IDX_ABILITY: rdata_nxt = {16'h0000, ability_r};
      `ANPS_IDX_EXPAN: rdata_nxt = {16'h0000, expan_word};
      `ANPS_IDX_IRQ_STAT: rdata_nxt = {30'h00000000, irq_stat_r};
      `ANPS_IDX_IRQ_MASK: rdata_nxt = {30'h00000000, irq_mask_r};
      default: rresp_err_nxt = 1'b1;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `ANPS_RESP_OKAY;
    end
    else if (rd_take)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata_nxt;
      s_axi_rresp <= rresp_err_nxt ? `ANPS_RESP_SLVERR : `ANPS_RESP_OKAY;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data in either order, response after both
  assign s_axi_awready = ~aw_got_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_got_r & ~s_axi_bvalid;
  assign wr_fire = aw_got_r & w_got_r & ~s_axi_bvalid;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_idx_r <= 5'h00;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ANPS_RESP_OKAY;
      irq_mask_r <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_got_r <= 1'b1;
        aw_idx_r <= s_axi_awaddr[6:2];
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_got_r <= 1'b1;
      end
      if (wr_fire)
      begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Status registers accept writes but drop them: read-only fields
        case (aw_idx_r)
          `ANPS_IDX_ABILITY: s_axi_bresp <= `ANPS_RESP_OKAY;
          `ANPS_IDX_EXPAN: s_axi_bresp <= `ANPS_RESP_OKAY;
          `ANPS_IDX_IRQ_STAT: s_axi_bresp <= `ANPS_RESP_OKAY;
          `ANPS_IDX_IRQ_MASK:
          begin
            s_axi_bresp <= `ANPS_RESP_OKAY;
            if (mask_strb_r)
            begin
              irq_mask_r <= mask_data_r;
            end
          end
          default: s_axi_bresp <= `ANPS_RESP_SLVERR;
        endcase
      end
      else if (s_axi_bvalid & s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // Data held from its own handshake; master may change wdata once taken
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mask_data_r <= 2'h0;
      mask_strb_r <= 1'b0;
    end
    else if (s_axi_wvalid & s_axi_wready)
    begin
      mask_data_r <= s_axi_wdata[1:0];
      mask_strb_r <= s_axi_wstrb[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Partner ability word, captured from each received page with bits 12..11 cleared
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ability_r <= `ANPS_ABIL_RESET;
    end
    else if (page_strobe)
    begin
      // Bits 15,14,13,10,9..5,4..0 kept; 12..11 forced to zero
      ability_r <= page_word & `ANPS_ABIL_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Latched expansion flags; a new event in the read cycle wins over the clear
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fault_r <= 1'b0;
      page_rx_r <= 1'b0;
    end
    else
    begin
      if (parallel_detect_fault)
      begin
        fault_r <= 1'b1;
      end
      else if (rd_expan)
      begin
        fault_r <= 1'b0;
      end
      if (page_strobe)
      begin
        page_rx_r <= 1'b1;
      end
      else if (rd_expan)
      begin
        page_rx_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt status: sticky, cleared by reading it, set wins
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_stat_r <= 2'h0;
    end
    else
    begin
      irq_stat_r[`ANPS_IRQ_PAGE] <= page_strobe |
        (irq_stat_r[`ANPS_IRQ_PAGE] & ~rd_stat);
      irq_stat_r[`ANPS_IRQ_FAULT] <= parallel_detect_fault |
        (irq_stat_r[`ANPS_IRQ_FAULT] & ~rd_stat);
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

endmodule

//--- pkg/anps_defines.vh
// Purpose: constants for the partner status register bank
// Assumes: AXI4-Lite, 32-bit data, one word per register
// Notes: offsets are register indexes; byte address is four times index
`ifndef ANPS_DEFINES_VH
`define ANPS_DEFINES_VH
`define ANPS_IDX_ABILITY 5'h05
`define ANPS_IDX_EXPAN 5'h06
`define ANPS_IDX_IRQ_STAT 5'h08
`define ANPS_IDX_IRQ_MASK 5'h09
`define ANPS_ABIL_RESET 16'h0000
`define ANPS_ABIL_MASK 16'hE7FF
`define ANPS_BIT_PDF 4
`define ANPS_BIT_PPC 3
`define ANPS_BIT_LPC 2
`define ANPS_BIT_PRX 1
`define ANPS_BIT_PNC 0
`define ANPS_IRQ_PAGE 0
`define ANPS_IRQ_FAULT 1
`define ANPS_RESP_OKAY 2'h0
`define ANPS_RESP_SLVERR 2'h2
`endif

//--- bench/anps_chk.sv
// Purpose: assertions on the partner status bank
// Assumes: one clock, read data one cycle after address
// Notes: flag copies mirror set-wins latching
`timescale 1ns/1ps
`include "anps_defines.vh"
module anps_chk
(
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire page_strobe,
  input wire [15:0] page_word,
  input wire parallel_detect_fault,
  input wire irq
);
  wire ar_go = s_axi_arvalid & s_axi_arready;
  wire ar5 = ar_go & (s_axi_araddr[6:2] == `ANPS_IDX_ABILITY);
  wire ar6 = ar_go & (s_axi_araddr[6:2] == `ANPS_IDX_EXPAN);
  reg pg_r;
  reg ft_r;
  always @(posedge aclk)
  begin
    pg_r <= aresetn & (page_strobe | (pg_r & ~ar6));
    ft_r <= aresetn & (parallel_detect_fault | (ft_r & ~ar6));
  end
  ////////////////////////////////////////
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ld5;
    page_strobe ##2 ar5;
  endsequence
  a_read_answer: assert property (ar_go |=> s_axi_rvalid)
    else $error("read not answered");
  a_ability_load: assert property (s_ld5 |=> s_axi_rdata == ($past(page_word, 3) & 16'hE7FF))
    else $error("ability word wrong");
  a_ability_rsvd: assert property (ar5 |=> s_axi_rdata[31:16] == 0 && s_axi_rdata[12:11] == 0)
    else $error("ability reserved set");
  a_expan_rsvd: assert property (ar6 |=> s_axi_rdata[31:5] == 0)
    else $error("expansion reserved set");
  a_local_page: assert property (ar6 |=> !s_axi_rdata[2])
    else $error("local page bit set");
  a_page_flag: assert property (ar6 |=> s_axi_rdata[1] == $past(pg_r))
    else $error("page flag wrong");
  a_fault_flag: assert property (ar6 |=> s_axi_rdata[4] == $past(ft_r))
    else $error("fault flag wrong");
  a_irq_reset: assert property ($rose(aresetn) |-> !irq)
    else $error("irq after reset");
endmodule
bind anps_regs anps_chk anps_chk_i (.*);

//--- bench/anps_peer.sv
// Purpose: remote partner handing over pages
// Assumes: capability levels change only with a page; fault level set on its own
// Notes: word bus shows the inverse once released
`timescale 1ns/1ps
module anps_peer
(
  input wire aclk,
  output reg page_strobe = 1'h0,
  output reg [15:0] page_word = 16'h0,
  output reg parallel_detect_fault = 1'h0,
  output reg partner_page_capable = 1'h0,
  output reg partner_negotiation_capable = 1'h0
);
  task send(input [15:0] w);
  begin
    page_strobe <= 1'h1;
    page_word <= w;
    partner_page_capable <= w[15];
    partner_negotiation_capable <= 1'h1;
    @(posedge aclk);
    page_strobe <= 1'h0;
    page_word <= ~w;
    @(posedge aclk);
  end
  endtask
  task fault(input v);
  begin
    parallel_detect_fault <= v;
    @(posedge aclk);
  end
  endtask
endmodule

//--- bench/anps_regs_bench.sv
// Purpose: self-checking bench for the partner status bank
// Assumes: results come back in issue order
// Notes: words from a fixed xorshift seed
`timescale 1ns/1ps
`include "anps_defines.vh"
module anps_regs_bench;
  reg aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  reg s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  reg [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  reg [31:0] s_axi_wdata = 32'h0, seed = 32'hB24C;
  reg [3:0] s_axi_wstrb = 4'hF;
  reg [15:0] w;
  reg [33:0] q[$];
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire page_strobe, parallel_detect_fault, partner_page_capable, partner_negotiation_capable;
  wire [15:0] page_word;
  integer n_fail = 0, n_compared = 0, k, i;
  anps_regs anps_regs_i (.*);
  anps_peer anps_peer_i (.*);
  ////////////////////////////////////////
  function [31:0] xs(input [31:0] x);
  begin
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  end
  endfunction
  task cmp(input [33:0] e, input [33:0] g);
  begin
    n_compared = n_compared + 1;
    if (g !== e)
    begin
      n_fail = n_fail + 1;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  end
  endtask
  task conclude;
  begin
    if (n_fail == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  // Valids held until their own ready edge; bready and rready held until valid
  task hs;
  begin
    k = 0;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) s_axi_bready <= 1'h0;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) s_axi_rready <= 1'h0;
      k = k + 1;
      if (k > 40)
      begin
        n_fail = n_fail + 1;
        conclude;
      end
    end
    while (s_axi_awvalid | s_axi_wvalid | s_axi_bready | s_axi_arvalid | s_axi_rready);
  end
  endtask
  task rd(input [7:0] a, input [33:0] e);
  begin
    q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    hs;
  end
  endtask
  task wr(input [7:0] a, input [31:0] d);
  begin
    q.push_back(34'h0);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    hs;
  end
  endtask
  // Settle past the edge before looking at a level
  task ck_irq(input e);
  begin
    #1;
    cmp({33'h0, e}, {33'h0, irq});
  end
  endtask
  initial
  forever #2 aclk = ~aclk;
  always @(posedge aclk)
  begin
    if (s_axi_bvalid & s_axi_bready)
      cmp(q.pop_front(), {s_axi_bresp, 32'h0});
    if (s_axi_rvalid & s_axi_rready)
      cmp(q.pop_front(), {s_axi_rresp, s_axi_rdata});
  end
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    rd(8'h14, 34'h0);
    rd(8'h18, 34'h0);
    for (i = 0; i < 6; i = i + 1)
    begin
      seed = xs(seed);
      w = seed[15:0];
      anps_peer_i.send(w);
      rd(8'h14, {18'h0, w & 16'hE7FF});
      rd(8'h18, {30'h0, w[15], 3'h3});
      rd(8'h18, {30'h0, w[15], 3'h1});
    end
    wr(8'h14, 32'hFFFFFFFF);
    wr(8'h18, 32'hFFFFFFFF);
    rd(8'h14, {18'h0, w & 16'hE7FF});
    rd(8'h18, {30'h0, w[15], 3'h1});
    rd(8'h3C, {`ANPS_RESP_SLVERR, 32'h0});
    anps_peer_i.fault(1'h1);
    anps_peer_i.fault(1'h0);
    rd(8'h18, {29'h0, 1'h1, w[15], 3'h1});
    rd(8'h18, {30'h0, w[15], 3'h1});
    anps_peer_i.fault(1'h1);
    rd(8'h18, {29'h0, 1'h1, w[15], 3'h1});
    rd(8'h18, {29'h0, 1'h1, w[15], 3'h1});
    anps_peer_i.fault(1'h0);
    ck_irq(1'h0);
    rd(8'h20, 34'h3);
    wr(8'h24, 32'h2);
    anps_peer_i.send(w);
    ck_irq(1'h0);
    wr(8'h24, 32'h1);
    ck_irq(1'h1);
    rd(8'h20, 34'h1);
    ck_irq(1'h0);
    conclude;
  end
endmodule
